// File: hdl/uebc_consts.svh
// Constants for the endpoint buffer command interpreter
`ifndef UEBC_CONSTS_SVH
`define UEBC_CONSTS_SVH
`define UEBC_NUM_EP 6
`define UEBC_EP_W 3
`define UEBC_PTR_W 6
`define UEBC_OFS_CMD 12'h000
`define UEBC_OFS_DATA 12'h004
`define UEBC_OFS_STATE 12'h008
`define UEBC_OFS_IRQ 12'h00C
`define UEBC_OP_SEL 8'h00
`define UEBC_OP_SELCLR 8'h10
`define UEBC_OP_SETST 8'h40
`define UEBC_OP_RDBUF 8'hF0
`define UEBC_OP_WRBUF 8'hF1
`define UEBC_OP_CLRBUF 8'hF2
`define UEBC_OP_VALBUF 8'hFA
`define UEBC_SB_FULL 0
`define UEBC_SB_STALL 1
`define UEBC_SB_SETUP 2
`define UEBC_SB_OVW 3
`define UEBC_SB_NAK 4
`define UEBC_SS_STALL 0
`define UEBC_SS_DIS 5
`define UEBC_SS_RFB 6
`define UEBC_SS_HI 7
`define UEBC_SS_MASK_CTRL 8'h81
`define UEBC_SS_MASK_GEN 8'h61
`define UEBC_CB_OVW 0
`define UEBC_EP_CTRL_OUT 3'h0
`define UEBC_EP_CTRL_IN 3'h1
`define UEBC_HTRANS_ACT 1
`define UEBC_HRESP_OKAY 1'h0
`endif

// File: hdl/uebc_pkg.sv
// Types shared by the endpoint buffer command interpreter
`include "uebc_consts.svh"
package uebc_pkg;
  typedef enum logic [2:0] {
    UEBC_M_IDLE = 3'h0,
    UEBC_M_SELST = 3'h1,
    UEBC_M_RD = 3'h3,
    UEBC_M_WR = 3'h2,
    UEBC_M_SETST = 3'h6,
    UEBC_M_CLRST = 3'h7
  } uebc_mode_t;
  typedef struct packed {
    logic full; logic stall; logic setup; logic ovw; logic nak;
    logic dis; logic rfb; logic hi; logic irq;
  } uebc_ep_t;
  typedef struct packed {
    logic rx_done; logic tx_done; logic nak; logic setup; logic [`UEBC_EP_W-1:0] ep;
  } uebc_sie_ev_t;
  typedef struct packed {
    logic sel_clr; logic clr_buf; logic val_buf; logic set_st;
    logic [`UEBC_EP_W-1:0] ep; logic [7:0] data;
  } uebc_ep_cmd_t;
  typedef struct packed {
    uebc_mode_t mode; logic [`UEBC_EP_W-1:0] ep; logic [`UEBC_EP_W-1:0] tgt;
    logic [`UEBC_PTR_W-1:0] ptr; logic [7:0] last_op; logic busy; logic wr;
    logic [11:0] addr; logic hready; logic hresp; logic [31:0] hrdata;
    logic [`UEBC_NUM_EP-1:0] nak; logic [`UEBC_NUM_EP-1:0] stall; logic [7:0] sie_rdata;
  } uebc_state_t;
endpackage

// File: hdl/uebc_buf_mem.sv
// Endpoint buffer memory with a controller port and a serial engine port
`timescale 1ns/1ns
module uebc_buf_mem #(
  parameter int EP_W = 3,
  parameter int PTR_W = 6
) (
  input wire logic hclk,
  input wire logic cpu_we,
  input wire logic [EP_W+PTR_W-1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic sie_we,
  input wire logic [EP_W+PTR_W-1:0] sie_waddr,
  input wire logic [7:0] sie_wdata,
  input wire logic [EP_W+PTR_W-1:0] sie_raddr,
  output logic [7:0] sie_rdata
);
  logic [7:0] mem [0:(1<<(EP_W+PTR_W))-1];

  // Controller write wins a same-address collision; engine writes are not blocked by buffer state
  always_ff @(posedge hclk) begin
    if (cpu_we) begin
      mem[cpu_addr] <= cpu_wdata;
    end
    if (sie_we && !(cpu_we && cpu_addr == sie_waddr)) begin
      mem[sie_waddr] <= sie_wdata;
    end
  end

  assign cpu_rdata = mem[cpu_addr];
  assign sie_rdata = mem[sie_raddr];
endmodule

// File: hdl/uebc_ep_stat.sv
// Per-endpoint status flags updated by commands and serial engine events
`timescale 1ns/1ns
module uebc_ep_stat
  import uebc_pkg::*;
#(
  parameter int NUM_EP = `UEBC_NUM_EP
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire uebc_ep_cmd_t cmd,
  input wire uebc_sie_ev_t sie_ev,
  input wire logic sie_bus_reset,
  output uebc_ep_t [NUM_EP-1:0] ep_st
);
  uebc_ep_t [NUM_EP-1:0] st_q;
  // Unpacked so each generate branch drives a variable of its own
  uebc_ep_t st_d [NUM_EP];

  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    localparam bit IS_OUT = (i % 2) == 0;
    localparam bit IS_CTRL = i < 2;
    localparam logic [7:0] MASK = IS_CTRL ? `UEBC_SS_MASK_CTRL : `UEBC_SS_MASK_GEN;
    always_comb begin
      logic hit_c;
      logic hit_e;
      hit_c = 32'(cmd.ep) == i;
      hit_e = 32'(sie_ev.ep) == i;
      st_d[i] = st_q[i];
      if (cmd.sel_clr && hit_c) begin
        st_d[i].irq = 1'b0;
        if (i == 0) begin
          st_d[i].setup = 1'b0;
          st_d[i].ovw = 1'b0;
        end
      end
      if (cmd.clr_buf && hit_c && IS_OUT && !st_q[i].ovw) begin
        st_d[i].full = 1'b0;
      end
      if (cmd.val_buf && hit_c && !IS_OUT && !(i == 1 && st_q[0].ovw)) begin
        st_d[i].full = 1'b1;
      end
      if (cmd.set_st && hit_c) begin
        if (MASK[`UEBC_SS_STALL]) st_d[i].stall = cmd.data[`UEBC_SS_STALL];
        if (MASK[`UEBC_SS_DIS]) st_d[i].dis = cmd.data[`UEBC_SS_DIS];
        if (MASK[`UEBC_SS_RFB]) st_d[i].rfb = cmd.data[`UEBC_SS_RFB];
        if (MASK[`UEBC_SS_HI]) st_d[i].hi = cmd.data[`UEBC_SS_HI];
      end
      // Engine events come last so a set in the clearing cycle is kept
      if (sie_ev.rx_done && hit_e && IS_OUT) begin
        if (sie_ev.setup && IS_CTRL) begin
          st_d[i].ovw = st_q[i].full;
          st_d[i].full = 1'b1;
          st_d[i].setup = 1'b1;
          st_d[i].stall = 1'b0;
          st_d[i].irq = 1'b1;
          st_d[i].nak = 1'b0;
        end else if (st_q[i].full) begin
          st_d[i].nak = 1'b1;
        end else if (!st_q[i].dis && !st_q[i].stall) begin
          st_d[i].full = 1'b1;
          st_d[i].setup = 1'b0;
          st_d[i].irq = 1'b1;
          st_d[i].nak = 1'b0;
        end
      end
      if (sie_ev.tx_done && hit_e && !IS_OUT) begin
        st_d[i].full = 1'b0;
        st_d[i].irq = 1'b1;
        st_d[i].nak = 1'b0;
      end
      if (sie_ev.nak && hit_e) st_d[i].nak = 1'b1;
      if (sie_bus_reset) st_d[i].dis = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        st_q[i] <= st_d[i];
      end
    end
  end
  assign ep_st = st_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ovw_blocks_clear: assert property (cmd.clr_buf && cmd.ep == 3'h0 && st_q[0].ovw &&
    st_q[0].full |=> st_q[0].full) else $error("clear freed an overwritten buffer");
  a_val_blocked: assert property (cmd.val_buf && cmd.ep == 3'h1 && st_q[0].ovw &&
    !st_q[1].full && !sie_ev.tx_done |=> !st_q[1].full)
    else $error("control input validated while overwritten");
  a_rx_sets_full: assert property (sie_ev.rx_done && sie_ev.ep == 3'h2 && !st_q[2].full &&
    !st_q[2].dis && !st_q[2].stall && !(cmd.clr_buf && cmd.ep == 3'h2) |=> st_q[2].full)
    else $error("received packet did not fill buffer");
  a_full_refuses: assert property (sie_ev.rx_done && sie_ev.ep == 3'h2 && st_q[2].full
    |=> st_q[2].nak) else $error("full buffer did not refuse packet");
  a_setst_masked: assert property (cmd.set_st && cmd.ep == 3'h0 |=>
    $stable(st_q[0].dis) && st_q[0].hi == $past(cmd.data[7]))
    else $error("set status touched a bit outside the type mask");
  a_selclr_irq: assert property (cmd.sel_clr && cmd.ep == 3'h3 &&
    !(sie_ev.ep == 3'h3 && sie_ev.tx_done) |=> !st_q[3].irq)
    else $error("interrupt not cleared by select");
  a_bus_reset_en: assert property (sie_bus_reset |=> !st_q[2].dis && !st_q[4].dis)
    else $error("bus reset left an endpoint disabled");
endmodule

// File: hdl/uebc_top.sv
// Endpoint buffer command interpreter behind an AHB-Lite register slave
// Operation
// - Select points buffer pointer at start
// - Select opcode equals physical endpoint number
// - One optional status read after select
// - Select-clear also clears endpoint interrupt
// - Select-clear on control out clears setup, overwritten
// - Set status writes bits 7..5 and 0
// - Set status opcode is 40h plus endpoint
// - Only type-applicable status bits are settable
// - Buffer reads return next byte, pointer advances
// - Read command keeps pointer; resumable after non-select commands
// - Buffer writes store byte, pointer advances
// - Write command keeps pointer; selects break it
// - Good host packet sets output buffer full
// - Full output buffer answers NAK to host
// - Clear buffer releases it for new packets
// - Clear buffer status bit0 flags overwritten
// - Clear ignored while overwritten is set
// - Validate sets input buffer full for sending
// - No control input validate while overwritten
// - Status byte full stall setup ovw nak
// - Disable bit disables; bus reset enables all
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
module uebc_top
  import uebc_pkg::*;
#(
  parameter int NUM_EP = `UEBC_NUM_EP
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire uebc_sie_ev_t sie_ev,
  input wire logic sie_bus_reset,
  input wire logic sie_we,
  input wire logic [`UEBC_EP_W+`UEBC_PTR_W-1:0] sie_waddr,
  input wire logic [7:0] sie_wdata,
  input wire logic [`UEBC_EP_W+`UEBC_PTR_W-1:0] sie_raddr,
  output logic [7:0] sie_rdata,
  output logic [NUM_EP-1:0] sie_nak,
  output logic [NUM_EP-1:0] sie_stall
);
  // ************************************************************
  // Declarations
  // ************************************************************
  uebc_state_t q;
  uebc_state_t d;
  uebc_ep_cmd_t cmd;
  uebc_ep_t [NUM_EP-1:0] ep_st;
  logic cpu_we;
  logic [7:0] cpu_rdata;
  logic [7:0] mem_sie_rdata;
  logic accept;
  logic [7:0] op;
  logic cmd_wr;
  logic data_wr;
  logic data_rd;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] status_byte(uebc_ep_t e);
    logic [7:0] b;
    b = 8'h00;
    b[`UEBC_SB_FULL] = e.full;
    b[`UEBC_SB_STALL] = e.stall;
    b[`UEBC_SB_SETUP] = e.setup;
    b[`UEBC_SB_OVW] = e.ovw;
    b[`UEBC_SB_NAK] = e.nak;
    return b;
  endfunction

  function automatic logic in_range(logic [7:0] v, logic [7:0] base);
    return v >= base && v < 8'(32'(base) + NUM_EP);
  endfunction

  // ************************************************************
  // Bus decode
  // ************************************************************
  // A transfer is taken when the previous one has finished, so every
  // access costs exactly one wait state and needs no address pipeline.
  assign accept = hsel && htrans[`UEBC_HTRANS_ACT] && hready;
  assign op = hwdata[7:0];
  assign cmd_wr = q.busy && q.wr && q.addr == `UEBC_OFS_CMD;
  assign data_wr = q.busy && q.wr && q.addr == `UEBC_OFS_DATA;
  assign data_rd = q.busy && !q.wr && q.addr == `UEBC_OFS_DATA;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    d = q;
    cmd = '0;
    cmd.ep = q.ep;
    cpu_we = 1'b0;
    if (q.busy) begin
      d.busy = 1'b0;
      d.hready = 1'b1;
      d.hrdata = 32'h0000_0000;
    end
    if (cmd_wr) begin
      d.last_op = op;
      d.mode = UEBC_M_IDLE;
      if (in_range(op, `UEBC_OP_SEL)) begin
        d.ep = `UEBC_EP_W'(op - `UEBC_OP_SEL);
        d.ptr = '0;
        d.mode = UEBC_M_SELST;
      end else if (in_range(op, `UEBC_OP_SELCLR)) begin
        d.ep = `UEBC_EP_W'(op - `UEBC_OP_SELCLR);
        d.ptr = '0;
        d.mode = UEBC_M_SELST;
        cmd.sel_clr = 1'b1;
        cmd.ep = `UEBC_EP_W'(op - `UEBC_OP_SELCLR);
      end else if (in_range(op, `UEBC_OP_SETST)) begin
        d.tgt = `UEBC_EP_W'(op - `UEBC_OP_SETST);
        d.mode = UEBC_M_SETST;
      end else if (op == `UEBC_OP_RDBUF) begin
        d.mode = UEBC_M_RD;
      end else if (op == `UEBC_OP_WRBUF) begin
        d.mode = UEBC_M_WR;
      end else if (op == `UEBC_OP_CLRBUF) begin
        cmd.clr_buf = 1'b1;
        d.mode = UEBC_M_CLRST;
      end else if (op == `UEBC_OP_VALBUF) begin
        cmd.val_buf = 1'b1;
      end
    end
    if (data_wr) begin
      unique case (q.mode)
        UEBC_M_WR: begin
          cpu_we = 1'b1;
          d.ptr = q.ptr + 1'b1;
        end
        UEBC_M_SETST: begin
          // Only the set-status opcode arms this write; it is used once
          cmd.set_st = 1'b1;
          cmd.ep = q.tgt;
          cmd.data = hwdata[7:0];
          d.mode = UEBC_M_IDLE;
        end
        UEBC_M_IDLE, UEBC_M_SELST, UEBC_M_RD, UEBC_M_CLRST: begin
          d.mode = q.mode;
        end
      endcase
    end
    if (data_rd) begin
      unique case (q.mode)
        UEBC_M_SELST: begin
          d.hrdata = {24'h000000, status_byte(ep_st[q.ep])};
          d.mode = UEBC_M_IDLE;
        end
        UEBC_M_CLRST: begin
          d.hrdata[`UEBC_CB_OVW] = ep_st[q.ep].ovw;
          d.mode = UEBC_M_IDLE;
        end
        UEBC_M_RD: begin
          d.hrdata = {24'h000000, cpu_rdata};
          d.ptr = q.ptr + 1'b1;
        end
        UEBC_M_IDLE, UEBC_M_WR, UEBC_M_SETST: begin
          d.hrdata = 32'h0000_0000;
        end
      endcase
    end
    if (q.busy && !q.wr && q.addr == `UEBC_OFS_STATE) begin
      d.hrdata = {8'h00, q.last_op, 2'h0, q.mode, q.ep, 2'h0, q.ptr};
    end
    if (q.busy && !q.wr && q.addr == `UEBC_OFS_IRQ) begin
      for (int i = 0; i < NUM_EP; i++) begin
        d.hrdata[i] = ep_st[i].irq;
      end
    end
    if (accept) begin
      d.busy = 1'b1;
      d.hready = 1'b0;
      d.wr = hwrite;
      d.addr = haddr[11:0];
    end
    d.hresp = `UEBC_HRESP_OKAY;
    // The engine samples registered copies of these flags, one cycle after ep_st changes
    for (int i = 0; i < NUM_EP; i++) begin
      d.nak[i] = (i % 2 == 0) && ep_st[i].full;
      d.stall[i] = ep_st[i].stall;
    end
    d.sie_rdata = mem_sie_rdata;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{mode: UEBC_M_IDLE, hready: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.hready;
  assign hresp = q.hresp;
  assign hrdata = q.hrdata;
  assign sie_nak = q.nak;
  assign sie_stall = q.stall;
  assign sie_rdata = q.sie_rdata;

  // ************************************************************
  // Submodules
  // ************************************************************
  uebc_buf_mem #(
    .EP_W(`UEBC_EP_W),
    .PTR_W(`UEBC_PTR_W)
  ) u_mem (
    .hclk(hclk),
    .cpu_we(cpu_we),
    .cpu_addr({q.ep, q.ptr}),
    .cpu_wdata(hwdata[7:0]),
    .cpu_rdata(cpu_rdata),
    .sie_we(sie_we),
    .sie_waddr(sie_waddr),
    .sie_wdata(sie_wdata),
    .sie_raddr(sie_raddr),
    .sie_rdata(mem_sie_rdata)
  );

  uebc_ep_stat #(
    .NUM_EP(NUM_EP)
  ) u_stat (
    .hclk(hclk),
    .hresetn(hresetn),
    .cmd(cmd),
    .sie_ev(sie_ev),
    .sie_bus_reset(sie_bus_reset),
    .ep_st(ep_st)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_select_ptr: assert property (cmd_wr && op < 8'h06 |=>
    q.ptr == '0 && 8'(q.ep) == $past(op) && q.mode == UEBC_M_SELST)
    else $error("select did not point at buffer start");
  a_selclr_rewind: assert property (cmd_wr && op >= 8'h10 && op < 8'h16 |=>
    q.ptr == '0 && cmd.sel_clr == 1'b0)
    else $error("select-clear did not rewind pointer");
  a_rd_advance: assert property (data_rd && q.mode == UEBC_M_RD |=>
    q.ptr == $past(q.ptr) + 1'b1 && q.hrdata[7:0] == $past(cpu_rdata))
    else $error("buffer read did not advance");
  a_wr_advance: assert property (data_wr && q.mode == UEBC_M_WR |->
    cpu_we ##1 q.ptr == $past(q.ptr) + 1'b1)
    else $error("buffer write did not advance");
  a_rdbuf_keeps: assert property (cmd_wr && op == 8'hF0 |=>
    $stable(q.ptr) && q.mode == UEBC_M_RD)
    else $error("read command moved the pointer");
  a_setst_opcode: assert property (cmd_wr && op == 8'h42 ##[2:3] data_wr |->
    cmd.set_st && cmd.ep == 3'h2)
    else $error("set status aimed at wrong endpoint");
  a_status_byte: assert property (data_rd && q.mode == UEBC_M_SELST |=>
    q.hrdata[4:0] == $past({ep_st[q.ep].nak, ep_st[q.ep].ovw, ep_st[q.ep].setup,
    ep_st[q.ep].stall, ep_st[q.ep].full}) && q.mode == UEBC_M_IDLE)
    else $error("select status byte wrong");
  a_clr_byte: assert property (data_rd && q.mode == UEBC_M_CLRST |=>
    q.hrdata[0] == $past(ep_st[q.ep].ovw))
    else $error("clear buffer byte wrong");
  a_one_wait: assert property (accept |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not finish after one wait state");
  a_nak_follows: assert property (ep_st[0].full |=> sie_nak[0])
    else $error("full control output not refused");
endmodule

// File: tb/uebc_sie_model.sv
// Serial engine stand-in that delivers host packets and bus resets
`timescale 1ns/1ns
module uebc_sie_model
  import uebc_pkg::*;
(
  input wire logic hclk,
  input wire logic [`UEBC_NUM_EP-1:0] sie_nak,
  output uebc_sie_ev_t sie_ev,
  output logic sie_bus_reset,
  output logic sie_we,
  output logic [`UEBC_EP_W+`UEBC_PTR_W-1:0] sie_waddr,
  output logic [7:0] sie_wdata,
  output logic [`UEBC_EP_W+`UEBC_PTR_W-1:0] sie_raddr
);
  initial begin
    sie_ev = '0;
    sie_bus_reset = 1'b0;
    sie_we = 1'b0;
    sie_waddr = '0;
    sie_wdata = 8'h00;
    sie_raddr = '0;
  end

  // Read port sweeps so it never sits on one address
  always @(posedge hclk) begin
    sie_raddr <= sie_raddr + 1'b1;
  end

  // A full OUT buffer is answered with NAK; SETUP is never refused
  task automatic rx(input logic [`UEBC_EP_W-1:0] ep, input logic setup, input logic [7:0] d);
    @(posedge hclk);
    if (sie_nak[ep] === 1'b1 && !setup) begin
      sie_ev <= '{1'b0, 1'b0, 1'b1, 1'b0, ep};
    end else begin
      sie_we <= 1'b1;
      sie_waddr <= {ep, 6'h00};
      sie_wdata <= d;
      sie_ev <= '{1'b1, 1'b0, 1'b0, setup, ep};
    end
    @(posedge hclk);
    sie_we <= 1'b0;
    sie_wdata <= ~d;
    sie_ev <= '0;
    @(posedge hclk);
  endtask

  task automatic bus_reset();
    @(posedge hclk);
    sie_bus_reset <= 1'b1;
    @(posedge hclk);
    sie_bus_reset <= 1'b0;
    @(posedge hclk);
  endtask
endmodule

// File: tb/uebc_top_bench.sv
// Self-checking bench for the endpoint buffer command interpreter
`timescale 1ns/1ns
module uebc_top_bench;
  import uebc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, sie_bus_reset, sie_we;
  uebc_sie_ev_t sie_ev;
  logic [8:0] sie_waddr, sie_raddr;
  logic [7:0] sie_wdata, sie_rdata;
  logic [5:0] sie_nak, sie_stall;
  int fail_count = 0;
  int compares = 0;

  initial begin
    forever #4 hclk = ~hclk;
  end

  uebc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sie_ev(sie_ev),
    .sie_bus_reset(sie_bus_reset), .sie_we(sie_we), .sie_waddr(sie_waddr),
    .sie_wdata(sie_wdata), .sie_raddr(sie_raddr), .sie_rdata(sie_rdata),
    .sie_nak(sie_nak), .sie_stall(sie_stall));

  uebc_sie_model sie (.hclk(hclk), .sie_nak(sie_nak), .sie_ev(sie_ev),
    .sie_bus_reset(sie_bus_reset), .sie_we(sie_we), .sie_waddr(sie_waddr),
    .sie_wdata(sie_wdata), .sie_raddr(sie_raddr));

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 40) begin
      $display("ERROR bus wait expected ready seen stuck");
      fail_count++;
    end
  endtask

  task cmd(input logic [7:0] op);
    xfer(1'b1, `UEBC_OFS_CMD, op);
  endtask

  // Select an endpoint and judge the masked status byte
  task st(input logic [7:0] ep, input logic [7:0] exp, input logic [7:0] m, input string what);
    cmd(ep);
    xfer(1'b0, `UEBC_OFS_DATA, 8'h00);
    chk(what, {24'h0, exp & m}, {24'h0, rd[7:0] & m});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    xfer(1'b0, `UEBC_OFS_STATE, 8'h00);
    chk("state", 32'h0, rd);
    xfer(1'b0, `UEBC_OFS_IRQ, 8'h00);
    chk("irq", 32'h0, rd);
    xfer(1'b1, 12'h010, 8'hFF);
    xfer(1'b0, 12'h010, 8'h00);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask

  task t_buffer();
    for (int i = 0; i < 6; i++) begin
      cmd(i[7:0]);
      xfer(1'b0, `UEBC_OFS_STATE, 8'h00);
      chk("sel ep", i, {29'h0, rd[10:8]});
    end
    cmd(8'h03);
    cmd(`UEBC_OP_WRBUF);
    for (int i = 0; i < 3; i++) xfer(1'b1, `UEBC_OFS_DATA, 8'hA0 + i[7:0]);
    cmd(`UEBC_OP_CLRBUF);
    cmd(`UEBC_OP_WRBUF);
    xfer(1'b1, `UEBC_OFS_DATA, 8'hA3);
    xfer(1'b0, `UEBC_OFS_STATE, 8'h00);
    chk("wr ptr", 32'h4, {26'h0, rd[5:0]});
    cmd(8'h03);
    xfer(1'b0, `UEBC_OFS_STATE, 8'h00);
    chk("sel ptr", 32'h0, {26'h0, rd[5:0]});
    cmd(`UEBC_OP_RDBUF);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b0, `UEBC_OFS_DATA, 8'h00);
      chk("rd byte", 32'hA0 + i, rd);
    end
    cmd(`UEBC_OP_CLRBUF);
    cmd(`UEBC_OP_RDBUF);
    xfer(1'b0, `UEBC_OFS_DATA, 8'h00);
    chk("rd resume", 32'hA2, rd);
    $display("test buffer done");
  endtask

  task t_out();
    sie.rx(3'h2, 1'b0, 8'h5A);
    st(8'h02, 8'h01, 8'h01, "full");
    chk("nak out", 32'h1, {31'h0, sie_nak[2]});
    wait (sie_raddr == 9'h080);
    @(posedge hclk);
    #1 chk("engine rd", 32'h5A, {24'h0, sie_rdata});
    @(posedge hclk);
    sie.rx(3'h2, 1'b0, 8'h66);
    st(8'h02, 8'h11, 8'h19, "nak sent");
    cmd(`UEBC_OP_RDBUF);
    xfer(1'b0, `UEBC_OFS_DATA, 8'h00);
    chk("kept pkt", 32'h5A, rd);
    cmd(`UEBC_OP_CLRBUF);
    xfer(1'b0, `UEBC_OFS_DATA, 8'h00);
    chk("clr byte", 32'h0, {31'h0, rd[0]});
    st(8'h02, 8'h00, 8'h01, "released");
    chk("nak gone", 32'h0, {31'h0, sie_nak[2]});
    sie.rx(3'h2, 1'b0, 8'h77);
    st(8'h02, 8'h01, 8'h01, "reaccept");
    $display("test out done");
  endtask

  task t_setup();
    sie.rx(3'h0, 1'b0, 8'h11);
    sie.rx(3'h0, 1'b1, 8'h22);
    st(8'h00, 8'h0D, 8'h0D, "ovw set");
    xfer(1'b0, `UEBC_OFS_IRQ, 8'h00);
    chk("irq set", 32'h1, {31'h0, rd[0]});
    cmd(`UEBC_OP_CLRBUF);
    xfer(1'b0, `UEBC_OFS_DATA, 8'h00);
    chk("clr ovw", 32'h1, {31'h0, rd[0]});
    st(8'h00, 8'h01, 8'h01, "clr refused");
    cmd(8'h01);
    cmd(`UEBC_OP_VALBUF);
    st(8'h01, 8'h00, 8'h01, "val refused");
    cmd(`UEBC_OP_SELCLR);
    xfer(1'b0, `UEBC_OFS_DATA, 8'h00);
    xfer(1'b0, `UEBC_OFS_IRQ, 8'h00);
    chk("irq clr", 32'h0, {31'h0, rd[0]});
    st(8'h00, 8'h00, 8'h0C, "setup ovw clr");
    cmd(`UEBC_OP_CLRBUF);
    xfer(1'b0, `UEBC_OFS_DATA, 8'h00);
    st(8'h00, 8'h00, 8'h01, "ep0 clr");
    cmd(8'h01);
    cmd(`UEBC_OP_VALBUF);
    st(8'h01, 8'h01, 8'h01, "validated");
    $display("test setup done");
  endtask

  task t_status();
    for (int i = 0; i < 6; i++) begin
      cmd(`UEBC_OP_SETST + i[7:0]);
      xfer(1'b1, `UEBC_OFS_DATA, 8'h01);
      @(posedge hclk);
      chk("stall on", 32'h1, {31'h0, sie_stall[i]});
      st(i[7:0], 8'h02, 8'h02, "stall bit");
      cmd(`UEBC_OP_SETST + i[7:0]);
      xfer(1'b1, `UEBC_OFS_DATA, 8'h00);
      @(posedge hclk);
      chk("stall off", 32'h0, {31'h0, sie_stall[i]});
    end
    cmd(8'h44);
    xfer(1'b1, `UEBC_OFS_DATA, 8'hFE);
    sie.rx(3'h4, 1'b0, 8'h33);
    st(8'h04, 8'h00, 8'h03, "disabled");
    sie.bus_reset();
    sie.rx(3'h4, 1'b0, 8'h34);
    st(8'h04, 8'h01, 8'h01, "reenabled");
    cmd(8'h40);
    xfer(1'b1, `UEBC_OFS_DATA, 8'h20);
    sie.rx(3'h0, 1'b0, 8'h35);
    st(8'h00, 8'h01, 8'h03, "ctrl no dis");
    $display("test status done");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task finish_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_buffer();
    t_out();
    t_setup();
    t_status();
    finish_test();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule
